// File: logic/uart_fc_defs.svh
// Constants for the flow-controlled serial port
`ifndef UART_FC_DEFS_SVH
`define UART_FC_DEFS_SVH
`define CLK_FREQ_HZ 250000000
`define BAUD_MIN_BPS 1200
`define BAUD_MAX_BPS 460800
`define BAUD_DEF_BPS 115200
`define DIV_WIDTH 20
`define DATA_BITS 8
`define RX_DEPTH_DEF 16
`define RX_ALMOST_DEF 4
`define LINE_IDLE 1'b1
`define HS_ASSERTED 1'b0
`define HS_DEASSERTED 1'b1
`endif

// File: logic/uart_fc_pkg.sv
// Types for the flow-controlled serial port
package uart_fc_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic parityErr;
    logic frameErr;
  } rx_char_type;
  typedef struct packed {
    logic parityEn;
    logic parityOdd;
  } frame_cfg_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b11,
    TX_STOP = 2'b10
  } tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_type;
endpackage

// File: logic/uart_tx.sv
// Serial transmitter with clear-to-send gating
`timescale 1ns/1ps
`include "uart_fc_defs.svh"
module uart_tx (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic [`DIV_WIDTH-1:0] baudDiv,
  input wire uart_fc_pkg::frame_cfg_type cfg,
  input wire logic clearOk,
  // Byte stream
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  // Line
  output logic txLine,
  output logic txBusy
);
  import uart_fc_pkg::*;
  tx_state_type state_r, state_nxt;
  logic [`DIV_WIDTH-1:0] cnt_r;
  logic [2:0] bitIdx_r;
  logic [8:0] shift_r;
  logic parBit_r;
  logic line_r;
  wire tick = (cnt_r == '0);
  // Start only when clear-to-send asserted; in-flight char completes
  assign txReady = (state_r == TX_IDLE) && clearOk;
  wire start = txValid && txReady;
  assign txLine = line_r;
  assign txBusy = (state_r != TX_IDLE);
  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TX_IDLE: if (start) state_nxt = TX_START;
      TX_START: if (tick) state_nxt = TX_DATA;
      TX_DATA: if (tick && bitIdx_r == 3'd7 && (parBit_r || !cfg.parityEn)) state_nxt = TX_STOP;
      TX_STOP: if (tick) state_nxt = TX_IDLE;
    endcase
  end
  // Frame: start low, 8 data LSB first, optional parity, stop high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= TX_IDLE;
      cnt_r <= '0;
      bitIdx_r <= 3'd0;
      shift_r <= '0;
      parBit_r <= 1'b0;
      line_r <= `LINE_IDLE;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (tick || start) ? baudDiv : cnt_r - 1'b1;
      if (start) begin
        shift_r <= {^txData ^ cfg.parityOdd, txData};
        bitIdx_r <= 3'd0;
        parBit_r <= 1'b0;
        line_r <= 1'b0;
      end else if (tick) begin
        unique case (state_r)
          TX_IDLE: line_r <= `LINE_IDLE;
          TX_START: line_r <= shift_r[0];
          TX_DATA: begin
            if (bitIdx_r == 3'd7 && !parBit_r && cfg.parityEn) begin
              parBit_r <= 1'b1;
              line_r <= shift_r[8];
            end else if (bitIdx_r == 3'd7) begin
              parBit_r <= 1'b0;
              line_r <= 1'b1;
            end else begin
              bitIdx_r <= bitIdx_r + 3'd1;
              line_r <= shift_r[bitIdx_r + 3'd1];
            end
          end
          TX_STOP: line_r <= `LINE_IDLE;
        endcase
      end
    end
  end
  // Line idles high whenever no frame is in flight
  a_tx_idle_high: assert property (@(posedge clk_sys) disable iff (rst)
    $past(state_r) == TX_IDLE && state_r == TX_IDLE |-> txLine) else $error("tx line not idle high");
  a_tx_cts_gate: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == TX_IDLE && !clearOk |=> state_r == TX_IDLE) else $error("tx started without clear");
  a_tx_start_low: assert property (@(posedge clk_sys) disable iff (rst)
    start |=> !txLine) else $error("start bit not low");
endmodule

// File: logic/uart_rx.sv
// Serial receiver with parity check
`timescale 1ns/1ps
`include "uart_fc_defs.svh"
module uart_rx (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic [`DIV_WIDTH-1:0] baudDiv,
  input wire uart_fc_pkg::frame_cfg_type cfg,
  // Synchronised line
  input wire logic rxLine,
  // Received characters
  output logic charValid,
  output uart_fc_pkg::rx_char_type charOut
);
  import uart_fc_pkg::*;
  rx_state_type state_r, state_nxt;
  logic [`DIV_WIDTH-1:0] cnt_r;
  logic [2:0] bitIdx_r;
  logic [7:0] shift_r;
  logic parPhase_r, parErr_r, valid_r;
  rx_char_type char_r;
  wire tick = (cnt_r == '0);
  wire lastData = (bitIdx_r == 3'd7) && (!cfg.parityEn || parPhase_r);
  assign charValid = valid_r;
  assign charOut = char_r;
  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RX_IDLE: if (!rxLine) state_nxt = RX_START;
      RX_START: if (tick) state_nxt = rxLine ? RX_IDLE : RX_DATA;
      RX_DATA: if (tick && lastData) state_nxt = RX_STOP;
      RX_STOP: if (tick) state_nxt = RX_IDLE;
    endcase
  end
  // Sample mid-bit; first wait is half a bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= RX_IDLE;
      cnt_r <= '0;
      bitIdx_r <= 3'd0;
      shift_r <= '0;
      parPhase_r <= 1'b0;
      parErr_r <= 1'b0;
      valid_r <= 1'b0;
      char_r <= '0;
    end else begin
      state_r <= state_nxt;
      valid_r <= 1'b0;
      if (state_r == RX_IDLE) begin
        cnt_r <= baudDiv >> 1;
        bitIdx_r <= 3'd0;
        parPhase_r <= 1'b0;
        parErr_r <= 1'b0;
      end else if (!tick) begin
        cnt_r <= cnt_r - 1'b1;
      end else begin
        cnt_r <= baudDiv;
        unique case (state_r)
          RX_START: ;
          RX_DATA: begin
            if (bitIdx_r == 3'd7 && parPhase_r) begin
              parErr_r <= (^shift_r ^ cfg.parityOdd) != rxLine;
            end else begin
              shift_r <= {rxLine, shift_r[7:1]};
              if (bitIdx_r == 3'd7) parPhase_r <= 1'b1;
              else bitIdx_r <= bitIdx_r + 3'd1;
            end
          end
          RX_STOP: begin
            valid_r <= 1'b1;
            char_r <= '{data: shift_r, parityErr: parErr_r && cfg.parityEn, frameErr: !rxLine};
          end
          default: ;
        endcase
      end
    end
  end
  a_rx_parity_off: assert property (@(posedge clk_sys) disable iff (rst)
    charValid && !cfg.parityEn |-> !charOut.parityErr) else $error("parity flagged when disabled");
  a_rx_valid_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    charValid |=> !charValid) else $error("rx valid not a pulse");
endmodule

// File: logic/uart_fc_top.sv
// Flow-controlled serial port on shared pins
// Functional notes
// - A full-duplex serial transmitter and receiver with flow control done in hardware.
// - Optional parity checking on received characters, flagging a mismatch when enabled.
// - Frame and handshake match a conventional asynchronous serial controller.
// - The ready-to-receive output is driven and clear-to-send is sampled, both active low.
// - Both data lines rest high when idle.
// - A low handshake line means asserted and a high one deasserted.
// - After reset the transmit pin is an output driven high.
// - After reset the receive pin is an input with pull-up.
// - After reset the ready-to-receive pin is an output driven low.
// - After reset the clear-to-send pin is an input with pull-down.
`timescale 1ns/1ps
`include "uart_fc_defs.svh"
module uart_fc_top #(
  parameter int DEPTH = `RX_DEPTH_DEF,
  parameter int ALMOST = `RX_ALMOST_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic [`DIV_WIDTH-1:0] baudDiv,
  input wire uart_fc_pkg::frame_cfg_type cfg,
  // Transmit stream
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  // Receive stream
  output logic rxValid,
  input wire logic rxReady,
  output uart_fc_pkg::rx_char_type rxChar,
  output logic rxOverflow,
  // Shared pins
  output logic shared_pin_tx_o,
  output logic shared_pin_tx_oe,
  input wire logic shared_pin_rx_i,
  output logic shared_pin_rx_pu,
  output logic shared_pin_ready_out_n_o,
  output logic shared_pin_ready_out_n_oe,
  input wire logic shared_pin_clear_in_n_i,
  output logic shared_pin_clear_in_pd
);
  import uart_fc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // Refuse buffer sizes the pointer logic cannot serve
  if (DEPTH < 4 || (1 << AW) != DEPTH || ALMOST < 1 || ALMOST >= DEPTH) begin : g_bad_size
    $error("uart_fc_top: bad DEPTH/ALMOST");
  end
  logic [1:0] rxSync_r, ctsSync_r;
  logic readyN_r, overflow_r;
  logic [AW:0] wr_r, rd_r;
  rx_char_type mem_r [DEPTH];
  logic charValid;
  rx_char_type charIn;
  logic txBusy;
  // Two-stage synchronisers for the pin inputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxSync_r <= 2'b11;
      ctsSync_r <= 2'b00;
    end else begin
      rxSync_r <= {rxSync_r[0], shared_pin_rx_i};
      ctsSync_r <= {ctsSync_r[0], shared_pin_clear_in_n_i};
    end
  end
  // Clear-to-send low means asserted
  wire clearOk = (ctsSync_r[1] == `HS_ASSERTED);
  // Pin directions and pulls are fixed for the serial function
  assign shared_pin_tx_oe = 1'b1;
  assign shared_pin_rx_pu = 1'b1;
  assign shared_pin_ready_out_n_oe = 1'b1;
  assign shared_pin_clear_in_pd = 1'b1;
  assign shared_pin_ready_out_n_o = readyN_r;
  assign rxOverflow = overflow_r;
  // Receive buffer occupancy
  wire [AW:0] count = wr_r - rd_r;
  wire full = (count == (AW+1)'(DEPTH));
  wire push = charValid && !full;
  wire pop = rxValid && rxReady;
  assign rxValid = (wr_r != rd_r);
  assign rxChar = mem_r[rd_r[AW-1:0]];
  // Deassert ready-to-receive when space runs short, leaving slack for in-flight bytes
  wire roomLow = (count >= (AW+1)'(DEPTH - ALMOST));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      readyN_r <= `HS_ASSERTED;
      overflow_r <= 1'b0;
    end else begin
      if (push) begin
        mem_r[wr_r[AW-1:0]] <= charIn;
        wr_r <= wr_r + 1'b1;
      end
      if (pop) rd_r <= rd_r + 1'b1;
      readyN_r <= roomLow ? `HS_DEASSERTED : `HS_ASSERTED;
      overflow_r <= overflow_r || (charValid && full);
    end
  end
  // Transmitter
  uart_tx u_tx (
    .clk_sys(clk_sys),
    .rst(rst),
    .baudDiv(baudDiv),
    .cfg(cfg),
    .clearOk(clearOk),
    .txValid(txValid),
    .txReady(txReady),
    .txData(txData),
    .txLine(shared_pin_tx_o),
    .txBusy(txBusy)
  );
  // Receiver
  uart_rx u_rx (
    .clk_sys(clk_sys),
    .rst(rst),
    .baudDiv(baudDiv),
    .cfg(cfg),
    .rxLine(rxSync_r[1]),
    .charValid(charValid),
    .charOut(charIn)
  );
  a_rts_low_space: assert property (@(posedge clk_sys) disable iff (rst)
    count < (AW+1)'(DEPTH - ALMOST) |=> !shared_pin_ready_out_n_o) else $error("rts high with room");
  a_rts_high_full: assert property (@(posedge clk_sys) disable iff (rst)
    full |=> shared_pin_ready_out_n_o) else $error("rts low while full");
  a_pins_dir: assert property (@(posedge clk_sys)
    shared_pin_tx_oe && shared_pin_ready_out_n_oe && shared_pin_rx_pu && shared_pin_clear_in_pd)
    else $error("pin defaults lost");
  a_tx_after_rst: assert property (@(posedge clk_sys)
    $fell(rst) |-> shared_pin_tx_o && !shared_pin_ready_out_n_o) else $error("reset pin levels wrong");
  a_busy_no_ready: assert property (@(posedge clk_sys) disable iff (rst)
    txBusy |-> !txReady) else $error("ready while busy");
endmodule

// File: bench/host_serial.sv
// Host serial port model with handshaking
`timescale 1ns/1ps
module host_serial (
  // Clock
  input wire logic clk_sys,
  // Host data lines
  output logic hostTx,
  input wire logic hostRx,
  // Handshakes, active low
  input wire logic devReadyN,
  output logic hostReadyN
);
  int bitLen = 8;
  // Idle line and ready host
  initial begin
    hostTx = 1'b1;
    hostReadyN = 1'b0;
  end
  // Frame out, waits for device ready unless told not to
  task automatic send(input logic [7:0] d, input logic pe, pb, sb, obey);
    logic [10:0] f;
    f = pe ? {sb, pb, d, 1'b0} : {1'b1, sb, d, 1'b0};
    while (obey && devReadyN !== 1'b0) @(negedge clk_sys);
    for (int i = 0; i < (pe ? 11 : 10); i++) begin
      hostTx = f[i];
      repeat (bitLen) @(negedge clk_sys);
    end
    hostTx = 1'b1;
  endtask
  // Frame in, sampled mid-bit; data, then parity and stop
  task automatic recv(input logic pe, output logic [9:0] got);
    int t;
    t = 0;
    got = '1;
    while (hostRx !== 1'b0 && t < 3000) begin
      @(negedge clk_sys);
      t++;
    end
    repeat (bitLen / 2) @(negedge clk_sys);
    for (int i = 0; i < (pe ? 10 : 9); i++) begin
      repeat (bitLen) @(negedge clk_sys);
      got[i] = hostRx;
    end
  endtask
endmodule

// File: bench/tb_top.sv
// Testbench for the flow-controlled serial port
`timescale 1ns/1ps
`include "uart_fc_defs.svh"
module tb_top;
  import uart_fc_pkg::*;
  logic clk_sys, rst, txValid, txReady, rxValid, rxReady, rxOverflow;
  logic [`DIV_WIDTH-1:0] baudDiv;
  frame_cfg_type cfg;
  logic [7:0] txData;
  rx_char_type rxChar;
  logic txO, txOe, rxPu, rdyN, rdyOe, clrPd, hostTx, hostReadyN;
  int fail_count = 0;
  int comparisons = 0;
  // Device and host
  uart_fc_top #(.DEPTH(4), .ALMOST(2)) uart_fc_top_inst (.clk_sys(clk_sys), .rst(rst), .baudDiv(baudDiv),
    .cfg(cfg), .txValid(txValid), .txReady(txReady), .txData(txData), .rxValid(rxValid), .rxReady(rxReady),
    .rxChar(rxChar), .rxOverflow(rxOverflow), .shared_pin_tx_o(txO), .shared_pin_tx_oe(txOe),
    .shared_pin_rx_i(hostTx), .shared_pin_rx_pu(rxPu), .shared_pin_ready_out_n_o(rdyN),
    .shared_pin_ready_out_n_oe(rdyOe), .shared_pin_clear_in_n_i(hostReadyN), .shared_pin_clear_in_pd(clrPd));
  host_serial host_serial_inst (.clk_sys(clk_sys), .hostTx(hostTx), .hostRx(txO), .devReadyN(rdyN),
    .hostReadyN(hostReadyN));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Report and end
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Offer one byte until taken
  task automatic offer(input logic [7:0] d);
    txData = d;
    txValid = 1'b1;
    for (int t = 0; t < 3000 && txReady !== 1'b1; t++) @(negedge clk_sys);
    @(negedge clk_sys);
    txValid = 1'b0;
  endtask
  // Pop head of receive buffer
  task automatic pop(input logic [9:0] exp);
    for (int t = 0; t < 200 && rxValid !== 1'b1; t++) @(negedge clk_sys);
    check(rxChar, exp);
    rxReady = 1'b1;
    @(negedge clk_sys);
    rxReady = 1'b0;
    @(negedge clk_sys);
  endtask
  // Pin defaults after reset
  task automatic test_reset;
    check({txO, txOe, rxPu, rdyN, rdyOe, clrPd, rxValid, rxOverflow}, 10'h0ec);
  endtask
  // Transmit in every parity mode, receive meanwhile in even parity mode
  task automatic test_tx;
    logic [9:0] got;
    logic [7:0] d;
    for (int m = 0; m < 3; m++) begin
      cfg.parityEn = (m != 0);
      cfg.parityOdd = (m == 2);
      d = 8'ha6 + 8'(m);
      fork
        offer(d);
        host_serial_inst.recv(cfg.parityEn, got);
        if (m == 1) host_serial_inst.send(8'h3e, 1'b1, ^8'h3e, 1'b1, 1'b1);
      join
      check(got, {1'b1, cfg.parityEn ? ^d ^ cfg.parityOdd : 1'b1, d});
      repeat (10) @(negedge clk_sys);
      check({txO, txReady}, 2'h3);
    end
    pop({8'h3e, 2'h0});
  endtask
  // Clear-to-send gates new frames, not one in flight
  task automatic test_cts;
    logic [9:0] got;
    cfg = 2'h0;
    hostReadyN = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(txReady, 10'h0);
    txData = 8'h3c;
    txValid = 1'b1;
    repeat (40) @(negedge clk_sys);
    check(txO, 10'h1);
    hostReadyN = 1'b0;
    fork
      offer(8'h3c);
      host_serial_inst.recv(1'b0, got);
    join
    check(got, {2'h3, 8'h3c});
    fork
      offer(8'h5a);
      host_serial_inst.recv(1'b0, got);
      begin
        repeat (30) @(negedge clk_sys);
        hostReadyN = 1'b1;
      end
    join
    check(got, {2'h3, 8'h5a});
    hostReadyN = 1'b0;
  endtask
  // Parity and stop checks on received characters
  task automatic test_rx;
    cfg = 2'h2;
    host_serial_inst.send(8'h5b, 1'b1, ^8'h5b, 1'b1, 1'b1);
    pop({8'h5b, 2'h0});
    host_serial_inst.send(8'h5b, 1'b1, ~^8'h5b, 1'b1, 1'b1);
    pop({8'h5b, 2'h2});
    cfg = 2'h3;
    host_serial_inst.send(8'h5b, 1'b1, ~^8'h5b, 1'b1, 1'b1);
    pop({8'h5b, 2'h0});
    cfg = 2'h0;
    host_serial_inst.send(8'hc3, 1'b0, 1'b0, 1'b0, 1'b1);
    pop({8'hc3, 2'h1});
  endtask
  // Ready-to-receive drops near full, overflow when host ignores it
  task automatic test_flow;
    for (int i = 0; i < 5; i++) begin
      host_serial_inst.send(8'h10 + 8'(i), 1'b0, 1'b0, 1'b1, i < 2);
      repeat (3) @(negedge clk_sys);
      if (i < 2) check(rdyN, 10'(i == 1));
    end
    check(rxOverflow, 10'h1);
    for (int i = 0; i < 4; i++) pop({8'h10 + 8'(i), 2'h0});
    repeat (3) @(negedge clk_sys);
    check({rdyN, rxOverflow}, 10'h1);
  endtask
  // Longer bit time, both directions at once
  task automatic test_baud;
    logic [9:0] got;
    baudDiv = 20'h0_000b;
    host_serial_inst.bitLen = 12;
    fork
      offer(8'h96);
      host_serial_inst.recv(1'b0, got);
      host_serial_inst.send(8'h69, 1'b0, 1'b0, 1'b1, 1'b1);
    join
    check(got, {2'h3, 8'h96});
    pop({8'h69, 2'h0});
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    txValid = 1'b0;
    rxReady = 1'b0;
    txData = 8'h00;
    cfg = 2'h0;
    baudDiv = 20'h0_0007;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    test_reset;
    test_tx;
    test_cts;
    test_rx;
    test_flow;
    test_baud;
    give_verdict;
  end
  // Watchdog
  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end
endmodule
